// ### drfp_pkg.sv
// Purpose: shared constants and types for the dual rail fault protection
// Assumes: voltages arrive as millivolt codes from on-chip converters
// Notes: all thresholds are in millivolts, all counts in ref_clk cycles
package drfp_pkg;
  localparam int CLK_MHZ = 32'h7D; // 125 MHz core clock
  localparam int MV_W = 32'hC;
  localparam int PHASES = 32'h6;
  // regulation margins and arming levels
  localparam logic [11:0] OV_MARGIN_MV = 12'h0AF; // 175 mV
  localparam logic [11:0] UV_MARGIN_MV = 12'h190; // 400 mV
  localparam logic [11:0] UV_ARM_MV = 12'h1F4; // 500 mV
  localparam logic [11:0] OV_DVC_MV = 12'h708; // 1.8 V
  localparam logic [11:0] OV_DVC_OFS_MV = 12'h960; // 2.4 V
  localparam logic [11:0] OV_FLOOR_MV = 12'h0FA; // 250 mV
  localparam logic [11:0] MAX_CURRENT_SETTING_MV = 12'h4D8; // 1.24 V
  // total limit levels per power state and phase count
  localparam logic [11:0] TOT_FULL_MV = 12'h9C4; // 2.500 V
  localparam logic [11:0] TOT_N3_MV = 12'h672; // 1.650 V
  localparam logic [11:0] TOT_N4_MV = 12'h4E2; // 1.250 V
  localparam logic [11:0] TOT_N5_MV = 12'h3E8; // 1.000 V
  localparam logic [11:0] TOT_N6_MV = 12'h33E; // 0.830 V
  localparam logic [7:0] PS_FULL = 8'h00;
  localparam logic [7:0] PS_SCALE_HI = 8'h02;
  localparam logic [2:0] LOW_POWER_PHASES = 3'h2;
  localparam logic [2:0] MIN_PHASES = 3'h3;
  // slew: nanoseconds per millivolt step (20 and 5 mV/us)
  localparam int FAST_NS_PER_MV = 32'h32;
  localparam int SLOW_NS_PER_MV = 32'hC8;
  localparam int FAST_STEP_CYC = (FAST_NS_PER_MV * CLK_MHZ) / 1000;
  localparam int SLOW_STEP_CYC = (SLOW_NS_PER_MV * CLK_MHZ) / 1000;
  // extra settle time after a voltage change before checks re-arm
  localparam int REARM_US = 32'hA;
  localparam int REARM_CYC = REARM_US * CLK_MHZ;
  localparam logic [11:0] BOOT_MV = 12'h000;
  localparam logic [11:0] STEP_MV = 12'h001;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_OV_RAMP = 2'b01,
    ST_OV_DONE = 2'b11,
    ST_HIZ = 2'b10
  } drfp_state_t;

  typedef enum logic {
    SEC_MULTI = 1'b0,
    SEC_SINGLE = 1'b1
  } drfp_sec_t;

  // one phase output pin pair: drive enable and level
  typedef struct packed {
    logic oe;
    logic level;
  } drfp_pwm_t;

  // voltage set command toward one section
  typedef struct packed {
    logic valid;
    logic fast;
    logic [11:0] targetMv;
  } drfp_cmd_t;
endpackage

// ### drfp_sync.sv
// Purpose: two flip-flop synchroniser for asynchronous pin levels
// Assumes: each bit is an independent level
// Notes: first stage feeds only the second stage
`timescale 1ns/10ps
module drfp_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);
  logic [W-1:0] meta_r;

  // two-stage capture
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      meta_r <= '0;
      syncOut <= '0;
    end else begin
      meta_r <= asyncIn;
      syncOut <= meta_r;
    end
  end
endmodule // drfp_sync

// ### drfp_ramp.sv
// Purpose: reference ramp of one section toward its target voltage
// Assumes: one millivolt per step, step spacing sets the slew
// Notes: forceDown overrides commands and ramps fast to the floor
`timescale 1ns/10ps
module drfp_ramp
  import drfp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input drfp_pkg::drfp_cmd_t cmd,
  input wire logic cmdAccept,
  input wire logic forceDown,
  output logic [11:0] refMv,
  output logic changing
);
  logic [11:0] target_r;
  logic fast_r;
  logic [7:0] divCnt_r;

  initial begin
    if (FAST_STEP_CYC < 1 || SLOW_STEP_CYC > 256)
      $error("drfp_ramp: step spacing out of range");
  end

  // step pulse from the slew divider
  wire stepEn = (divCnt_r == 8'h00);
  wire [7:0] reload = fast_r ? 8'(FAST_STEP_CYC - 1) : 8'(SLOW_STEP_CYC - 1);
  wire goUp = (refMv < target_r);
  assign changing = (refMv != target_r);

  // target selection, a new command retargets mid-ramp
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      target_r <= BOOT_MV;
      fast_r <= 1'b1;
    end else if (forceDown) begin
      target_r <= OV_FLOOR_MV;
      fast_r <= 1'b1;
    end else if (cmd.valid && cmdAccept) begin
      target_r <= cmd.targetMv;
      fast_r <= cmd.fast;
    end
  end

  // slew divider and reference stepping
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      divCnt_r <= 8'h00;
      refMv <= BOOT_MV;
    end else begin
      divCnt_r <= stepEn ? reload : divCnt_r - 8'h01;
      if (stepEn && changing)
        refMv <= goUp ? refMv + STEP_MV : refMv - STEP_MV;
    end
  end
endmodule // drfp_ramp

// ### drfp_protect.sv
// Purpose: fault latch and output forcing for a two-section regulator
// Assumes: sense and indicator words are same-clock converter codes in mV;
//   comparator flags and enable pins are asynchronous
// Notes: latch clears only by srst or by the enable pin going low
// Behaviour
// - over-voltage when sense exceeds reference by 175 mV
// - over-voltage latches: offender low, other high impedance, offender ready off
// - under-voltage 400 mV below reference, armed once reference over 500 mV
// - under-voltage latches all high impedance, offender ready cleared
// - per-phase and total over-current; total handled like under-voltage
// - checks armed in soft-start, masked in changes, re-armed after delay
// - over-voltage threshold 1.8 V during changes, 2.4 V with offset
// - after over-voltage the offending reference ramps down to 250 mV
// - ramp-down: offender toggles high impedance and low, enable high
// - non-offending section stays high impedance with enable low
// - fault flag high while over-voltage latched
// - ramp ends all high impedance with offender below 250 mV
// - total indicator at or over 2.5 V at full power latches all high impedance, multi ready cleared
// - per-phase over-current holds that low-side on until it clears
// - current report at 1.24 V marks the programmed maximum current
// - power states above 00h cap active multi phases at two
// - states 01h and 02h scale total level by configured phase count
// - single section disabled by its pin, its commands rejected
// - slew 20 or 5 mV per us, new target retargets the ramp
`timescale 1ns/10ps
module drfp_protect
  import drfp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic enableIn,
  input wire logic singleSectionDisable,
  input wire logic [5:0] phaseOcIn,
  input wire logic singleOcIn,
  input wire logic [11:0] multiRailSenseMv,
  input wire logic [11:0] singleRailSenseMv,
  input drfp_pkg::drfp_cmd_t multiCmd,
  input drfp_pkg::drfp_cmd_t singleCmd,
  input wire logic offsetCommanded,
  input wire logic powerStateValid,
  input wire logic [7:0] powerStateCommand,
  input wire logic [2:0] phaseCountCfg,
  input wire logic [11:0] totalLimitIndicatorMv,
  input wire logic [11:0] currentReportIndicatorMv,
  input wire logic [6:0] loopPwm,
  input wire logic [6:0] loopDrive,
  input wire logic [1:0] loopDriverEnable,
  input wire logic [1:0] readyIn,
  output drfp_pkg::drfp_pwm_t [6:0] phasePwmOut,
  output logic [1:0] driverEnableOut,
  output logic faultFlagOut,
  output logic [1:0] railReadyOut,
  output logic [2:0] activePhaseCount,
  output logic currentAtMax,
  output logic [11:0] multiRefMv,
  output logic [11:0] singleRefMv,
  output logic singleCmdRejected,
  output drfp_pkg::drfp_state_t latchState,
  output drfp_pkg::drfp_sec_t faultSection
);
  localparam int SINGLE_IDX = PHASES;

  drfp_state_t state_r;
  drfp_state_t state_nxt;
  drfp_sec_t sec_r;
  drfp_sec_t sec_nxt;
  logic [7:0] powerState_r;
  logic [10:0] rearmM_r;
  logic [10:0] rearmS_r;
  drfp_pwm_t [6:0] pwm_nxt;
  logic [1:0] drvEn_nxt;
  logic [1:0] ready_nxt;
  logic [8:0] syncIn;
  logic [8:0] syncd;
  logic changingM;
  logic changingS;

  initial begin
    if (REARM_CYC > 2047 || REARM_CYC < 1)
      $error("drfp_protect: re-arm count does not fit its counter");
  end

  // over-voltage test against the margin or the fixed change threshold
  function automatic logic ovTrip(input logic [11:0] sense,
                                  input logic [11:0] refv,
                                  input logic masked,
                                  input logic offset);
    logic [12:0] limit;
    limit = {1'b0, refv} + {1'b0, OV_MARGIN_MV};
    if (masked)
      ovTrip = offset ? (sense > OV_DVC_OFS_MV) : (sense > OV_DVC_MV);
    else
      ovTrip = ({1'b0, sense} > limit);
  endfunction

  // under-voltage test, only above the arming reference
  function automatic logic uvTrip(input logic [11:0] sense,
                                  input logic [11:0] refv,
                                  input logic masked);
    logic [12:0] low;
    low = {1'b0, sense} + {1'b0, UV_MARGIN_MV};
    uvTrip = !masked && (refv > UV_ARM_MV) && (low < {1'b0, refv});
  endfunction

  assign syncIn = {enableIn, singleSectionDisable, singleOcIn, phaseOcIn};
  drfp_sync #(
    .W(9)
  ) u_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .asyncIn(syncIn),
    .syncOut(syncd)
  );

  wire enSync = syncd[8];
  wire singleOff = syncd[7];
  wire singleOc = syncd[6];
  wire [5:0] phaseOc = syncd[5:0];
  // latch clear: reset or enable pin low
  wire latchClear = srst || !enSync;

  // single section commands refused while disabled
  wire singleAccept = !singleOff;
  assign singleCmdRejected = singleCmd.valid && singleOff;

  wire ovRamping = (state_r == ST_OV_RAMP);
  wire forceM = (ovRamping || state_r == ST_OV_DONE) && sec_r == SEC_MULTI;
  wire forceS = (ovRamping || state_r == ST_OV_DONE) && sec_r == SEC_SINGLE;

  // reference ramps, forced to the floor after over-voltage
  drfp_ramp u_rampM (
    .ref_clk(ref_clk),
    .srst(latchClear),
    .cmd(multiCmd),
    .cmdAccept(1'b1),
    .forceDown(forceM),
    .refMv(multiRefMv),
    .changing(changingM)
  );

  drfp_ramp u_rampS (
    .ref_clk(ref_clk),
    .srst(latchClear),
    .cmd(singleCmd),
    .cmdAccept(singleAccept),
    .forceDown(forceS),
    .refMv(singleRefMv),
    .changing(changingS)
  );

  // settle counters hold checks off after each change
  always_ff @(posedge ref_clk) begin
    if (latchClear) begin
      rearmM_r <= 11'h000;
      rearmS_r <= 11'h000;
    end else begin
      if (changingM)
        rearmM_r <= 11'(REARM_CYC);
      else if (rearmM_r != 11'h000)
        rearmM_r <= rearmM_r - 11'h001;
      if (changingS)
        rearmS_r <= 11'(REARM_CYC);
      else if (rearmS_r != 11'h000)
        rearmS_r <= rearmS_r - 11'h001;
    end
  end

  wire maskM = changingM || (rearmM_r != 11'h000);
  wire maskS = changingS || (rearmS_r != 11'h000);

  wire ovM = ovTrip(multiRailSenseMv, multiRefMv, maskM, offsetCommanded);
  wire ovS = !singleOff &&
             ovTrip(singleRailSenseMv, singleRefMv, maskS, offsetCommanded);
  wire uvM = uvTrip(multiRailSenseMv, multiRefMv, maskM);
  wire uvS = !singleOff && uvTrip(singleRailSenseMv, singleRefMv, maskS);

  // power state capture, cleared with the latch
  always_ff @(posedge ref_clk) begin
    if (latchClear)
      powerState_r <= PS_FULL;
    else if (powerStateValid)
      powerState_r <= powerStateCommand;
  end

  wire lowPower = (powerState_r != PS_FULL);
  wire [2:0] capCount =
    (phaseCountCfg > LOW_POWER_PHASES) ? LOW_POWER_PHASES : phaseCountCfg;
  wire [2:0] phaseCount_nxt = lowPower ? capCount : phaseCountCfg;

  // total level scaled by configured phase count
  wire scaled = lowPower && (powerState_r <= PS_SCALE_HI);
  wire [11:0] scaledMv =
    (phaseCountCfg <= MIN_PHASES) ? TOT_N3_MV :
    (phaseCountCfg == 3'h4) ? TOT_N4_MV :
    (phaseCountCfg == 3'h5) ? TOT_N5_MV : TOT_N6_MV;
  wire [11:0] totLevel = scaled ? scaledMv : TOT_FULL_MV;
  // total over-current, armed even through changes
  wire totOc = (totalLimitIndicatorMv >= totLevel);

  // same-cycle faults: over-voltage first, multi section first
  wire ovAny = ovM || ovS;
  wire uvLike = uvM || uvS || totOc;

  // offending section output below the ramp floor
  wire offBelow = (sec_r == SEC_MULTI) ? (multiRailSenseMv < OV_FLOOR_MV) :
                  (singleRailSenseMv < OV_FLOOR_MV);

  // latch sequencing
  always_comb begin
    state_nxt = state_r;
    sec_nxt = sec_r;
    unique case (state_r)
      ST_RUN: begin
        if (ovAny) begin
          state_nxt = ST_OV_RAMP;
          sec_nxt = ovM ? SEC_MULTI : SEC_SINGLE;
        end else if (uvLike) begin
          state_nxt = ST_HIZ;
          sec_nxt = (uvM || totOc) ? SEC_MULTI : SEC_SINGLE;
        end
      end
      ST_OV_RAMP: begin
        // ramp done once the offender is below the floor
        if (offBelow)
          state_nxt = ST_OV_DONE;
      end
      ST_OV_DONE: state_nxt = ST_OV_DONE;
      ST_HIZ: state_nxt = ST_HIZ;
    endcase
  end

  // latch registers, released only by reset or enable
  always_ff @(posedge ref_clk) begin
    if (latchClear) begin
      state_r <= ST_RUN;
      sec_r <= SEC_MULTI;
    end else begin
      state_r <= state_nxt;
      sec_r <= sec_nxt;
    end
  end

  assign latchState = state_r;
  assign faultSection = sec_r;

  // phase output forcing per latch state
  always_comb begin
    logic isSingle;
    logic secOn;
    logic phaseOn;
    logic ocHere;
    logic offender;
    isSingle = 1'b0;
    secOn = 1'b0;
    phaseOn = 1'b0;
    ocHere = 1'b0;
    offender = 1'b0;
    for (int i = 0; i <= SINGLE_IDX; i++) begin
      isSingle = (i == SINGLE_IDX);
      secOn = isSingle ? !singleOff : 1'b1;
      phaseOn = isSingle || (3'(i) < activePhaseCount);
      ocHere = isSingle ? singleOc : phaseOc[i % PHASES];
      offender = (isSingle ? SEC_SINGLE : SEC_MULTI) == sec_r;
      pwm_nxt[i] = '{oe: 1'b0, level: 1'b0};
      unique case (state_r)
        ST_RUN: begin
          if (secOn && phaseOn) begin
            // per-phase over-current holds low side on
            if (ocHere)
              pwm_nxt[i] = '{oe: 1'b1, level: 1'b0};
            else
              pwm_nxt[i] = '{oe: loopDrive[i], level: loopPwm[i]};
          end
        end
        ST_OV_RAMP: begin
          // offender follows the ramp with only low or open
          if (offender && phaseOn && !offBelow)
            pwm_nxt[i] = '{oe: !loopPwm[i], level: 1'b0};
        end
        // everything open once latched or done
        ST_OV_DONE, ST_HIZ: pwm_nxt[i] = '{oe: 1'b0, level: 1'b0};
      endcase
    end
  end

  // driver enables and ready outputs per section
  always_comb begin
    drvEn_nxt = 2'b00;
    ready_nxt = 2'b00;
    for (int s = 0; s < 2; s++) begin
      unique case (state_r)
        ST_RUN: begin
          drvEn_nxt[s] = loopDriverEnable[s] && (s == 0 || !singleOff);
          ready_nxt[s] = readyIn[s] && (s == 0 || !singleOff);
        end
        ST_OV_RAMP: begin
          drvEn_nxt[s] = (1'(s) == sec_r) && !offBelow;
          ready_nxt[s] = (1'(s) != sec_r) && readyIn[s];
        end
        ST_OV_DONE, ST_HIZ: begin
          // only the latched section loses ready
          drvEn_nxt[s] = 1'b0;
          ready_nxt[s] = (1'(s) != sec_r) && readyIn[s];
        end
      endcase
    end
  end

  // registered pin outputs
  always_ff @(posedge ref_clk) begin
    if (latchClear) begin
      phasePwmOut <= '0;
      driverEnableOut <= 2'b00;
      railReadyOut <= 2'b00;
      faultFlagOut <= 1'b0;
    end else begin
      phasePwmOut <= pwm_nxt;
      driverEnableOut <= drvEn_nxt;
      railReadyOut <= ready_nxt;
      faultFlagOut <= (state_nxt == ST_OV_RAMP) ||
                      (state_nxt == ST_OV_DONE);
    end
  end

  // reporting outputs
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      activePhaseCount <= 3'h0;
      currentAtMax <= 1'b0;
    end else begin
      activePhaseCount <= phaseCount_nxt;
      // maximum current mark on the report indicator
      currentAtMax <= (currentReportIndicatorMv >= MAX_CURRENT_SETTING_MV);
    end
  end
endmodule // drfp_protect

// ### drfp_protect_sva.sv
// Purpose: port checks for the fault latch and output forcing
// Assumes: one clock domain, synchronous active high reset
// Notes: watches design outputs plus the phaseOcIn, powerStateValid and powerStateCommand inputs; bound to the top module
`timescale 1ns/10ps
module drfp_protect_chk
  import drfp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [5:0] phaseOcIn,
  input wire logic powerStateValid,
  input wire logic [7:0] powerStateCommand,
  input drfp_pkg::drfp_pwm_t [6:0] phasePwmOut,
  input wire logic [1:0] driverEnableOut,
  input wire logic faultFlagOut,
  input wire logic [1:0] railReadyOut,
  input wire logic [2:0] activePhaseCount,
  input drfp_pkg::drfp_state_t latchState,
  input drfp_pkg::drfp_sec_t faultSection
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  logic [6:0] oeBits;
  logic [5:0] multiHigh;
  // pin summaries: driven pins and multi phases driven high
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      oeBits[i] = phasePwmOut[i].oe;
    end
    for (int i = 0; i < 6; i++) begin
      multiHigh[i] = phasePwmOut[i].oe & phasePwmOut[i].level;
    end
  end
  // latch entry and a held latch
  sequence s_ovTrip;
    latchState == ST_RUN ##1 latchState == ST_OV_RAMP;
  endsequence
  sequence s_ovHeld;
    latchState == ST_OV_RAMP ##1 latchState == ST_OV_RAMP;
  endsequence
  property p_ovFlag;
    s_ovTrip |=> faultFlagOut;
  endproperty
  property p_ovOffender;
    s_ovHeld ##0 faultSection == SEC_MULTI |->
      driverEnableOut[0] && multiHigh == 6'h00;
  endproperty
  property p_ovOther;
    s_ovHeld ##0 faultSection == SEC_MULTI |->
      !driverEnableOut[1] && !oeBits[6];
  endproperty
  property p_ovDone;
    latchState == ST_OV_DONE [*2] |->
      oeBits == 7'h00 && driverEnableOut == 2'h0 && faultFlagOut;
  endproperty
  property p_uvHiz;
    latchState == ST_HIZ [*2] |-> oeBits == 7'h00;
  endproperty
  property p_uvReady;
    $rose(latchState == ST_HIZ) && faultSection == SEC_MULTI |=>
      !railReadyOut[0];
  endproperty
  property p_psCap;
    powerStateValid && powerStateCommand != PS_FULL |->
      ##[1:3] activePhaseCount == LOW_POWER_PHASES;
  endproperty
  property p_phaseOc;
    (phaseOcIn[0] && latchState == ST_RUN) [*5] |->
      phasePwmOut[0].oe && !phasePwmOut[0].level;
  endproperty
  a_ovFlag: assert property (p_ovFlag)
    else $error("flag not raised after over-voltage latch");
  a_ovOffender: assert property (p_ovOffender)
    else $error("offending section not held low with enable");
  a_ovOther: assert property (p_ovOther)
    else $error("other section not open with enable low");
  a_ovDone: assert property (p_ovDone)
    else $error("ramp end not fully open");
  a_uvHiz: assert property (p_uvHiz)
    else $error("pins driven while latched open");
  a_uvReady: assert property (p_uvReady)
    else $error("ready kept after open latch");
  a_psCap: assert property (p_psCap)
    else $error("phase count not capped");
  a_phaseOc: assert property (p_phaseOc)
    else $error("phase over-current low side not on");
endmodule // drfp_protect_chk

bind drfp_protect drfp_protect_chk u_chk (
  .ref_clk(ref_clk),
  .srst(srst),
  .phaseOcIn(phaseOcIn),
  .powerStateValid(powerStateValid),
  .powerStateCommand(powerStateCommand),
  .phasePwmOut(phasePwmOut),
  .driverEnableOut(driverEnableOut),
  .faultFlagOut(faultFlagOut),
  .railReadyOut(railReadyOut),
  .activePhaseCount(activePhaseCount),
  .latchState(latchState),
  .faultSection(faultSection)
);

// ### drfp_stage_model.sv
// Purpose: behavioural power stage of the multi section
// Assumes: output sags 1 mV a cycle unless a phase pushes high
// Notes: overshootMv adds an over-voltage only when the bench asks
`timescale 1ns/10ps
module drfp_stage_model
  import drfp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input drfp_pkg::drfp_pwm_t [6:0] phasePwmOut,
  input wire logic [1:0] driverEnableOut,
  input wire logic [11:0] refMv,
  input wire logic [11:0] overshootMv,
  output logic [11:0] senseMv
);
  logic [5:0] pushHigh;
  logic pushing;
  logic [11:0] sense_r;
  // any enabled phase driven high holds the output
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      pushHigh[i] = phasePwmOut[i].oe & phasePwmOut[i].level;
    end
  end
  assign pushing = driverEnableOut[0] & (|pushHigh);
  assign senseMv = sense_r;
  // low side or open phases let the output sag
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sense_r <= 12'h000;
    end else if (pushing) begin
      sense_r <= refMv + overshootMv;
    end else if (sense_r != 12'h000) begin
      sense_r <= sense_r - 12'h001;
    end
  end
endmodule // drfp_stage_model

// ### drfp_protect_tb.sv
// Purpose: self-checking bench for the fault latch
// Assumes: table rows never trip a fault
// Notes: stage model closes the sense loop of the multi section
`timescale 1ns/10ps
module drfp_protect_tb;
  import drfp_pkg::*;
  typedef struct packed {
    logic [7:0] ps;
    logic [2:0] cfg;
    logic [11:0] tot;
    logic [11:0] current_report_indicator;
    logic [2:0] expCnt;
    logic expMax;
  } drfp_row_t;
  localparam drfp_row_t ROWS [6] = '{
    '{8'h00, 3'h6, 12'h960, 12'h514, 3'h6, 1'b1},
    '{8'h01, 3'h3, 12'h640, 12'h3E8, 3'h2, 1'b0},
    '{8'h02, 3'h4, 12'h4B0, 12'h514, 3'h2, 1'b1},
    '{8'h01, 3'h5, 12'h3B6, 12'h3E8, 3'h2, 1'b0},
    '{8'h02, 3'h6, 12'h320, 12'h514, 3'h2, 1'b1},
    '{8'h03, 3'h5, 12'h960, 12'h3E8, 3'h2, 1'b0}};
  logic ref_clk, srst, enableIn, singleDisable, psValid;
  logic [5:0] phaseOcIn;
  logic [11:0] totalMv, imonMv, overshootMv, senseMv;
  logic [11:0] multiRefMv, singleRefMv;
  logic [7:0] psCmd;
  logic [2:0] phaseCfg, activePhaseCount;
  logic [6:0] loopPwm, oeAll;
  logic [1:0] driverEnableOut, railReadyOut;
  logic faultFlagOut, currentAtMax, singleCmdRejected, offsetOn;
  drfp_cmd_t multiCmd, singleCmd;
  drfp_pwm_t [6:0] phasePwmOut;
  drfp_state_t latchState;
  drfp_sec_t faultSection;
  int n_fail, tests_run, k;
  // design, far side, clock
  drfp_protect DUT (.ref_clk(ref_clk), .srst(srst), .enableIn(enableIn),
    .singleSectionDisable(singleDisable), .phaseOcIn(phaseOcIn),
    .singleOcIn(1'b0), .multiRailSenseMv(senseMv),
    .singleRailSenseMv(singleRefMv), .multiCmd(multiCmd),
    .singleCmd(singleCmd), .offsetCommanded(offsetOn),
    .powerStateValid(psValid), .powerStateCommand(psCmd),
    .phaseCountCfg(phaseCfg), .totalLimitIndicatorMv(totalMv),
    .currentReportIndicatorMv(imonMv), .loopPwm(loopPwm),
    .loopDrive(7'h7F), .loopDriverEnable(2'h3), .readyIn(2'h3),
    .phasePwmOut(phasePwmOut), .driverEnableOut(driverEnableOut),
    .faultFlagOut(faultFlagOut), .railReadyOut(railReadyOut),
    .activePhaseCount(activePhaseCount), .currentAtMax(currentAtMax),
    .multiRefMv(multiRefMv), .singleRefMv(singleRefMv),
    .singleCmdRejected(singleCmdRejected), .latchState(latchState),
    .faultSection(faultSection));
  drfp_stage_model u_stage (.ref_clk(ref_clk), .srst(srst),
    .phasePwmOut(phasePwmOut), .driverEnableOut(driverEnableOut),
    .refMv(multiRefMv), .overshootMv(overshootMv), .senseMv(senseMv));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      oeAll[i] = phasePwmOut[i].oe;
    end
  end
  // helpers: step, compare, bound, verdict
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic conclude();
    if (n_fail == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic limitHit(int cnt, int lim);
    if (cnt >= lim) begin
      n_fail++;
      conclude();
    end
  endtask
  task automatic pulsePs(logic [7:0] ps, logic [2:0] cfg);
    psCmd = ps;
    phaseCfg = cfg;
    psValid = 1'b1;
    tick(1);
    psValid = 1'b0;
    tick(3);
  endtask
  initial begin
    n_fail = 0;
    tests_run = 0;
    srst = 1'b1;
    enableIn = 1'b1;
    singleDisable = 1'b0;
    psValid = 1'b0;
    phaseOcIn = 6'h00;
    {totalMv, imonMv, overshootMv} = '0;
    psCmd = 8'h00;
    phaseCfg = 3'h6;
    loopPwm = 7'h7F;
    multiCmd = '0;
    singleCmd = '0;
    offsetOn = 1'b0;
    tick(5);
    check("latchState", ST_RUN, latchState);
    check("driverEnableOut", 2'h0, driverEnableOut);
    srst = 1'b0;
    tick(3);
    // disabled single section refuses its command
    singleDisable = 1'b1;
    tick(4);
    singleCmd = '{1'b1, 1'b1, 12'h100};
    #1;
    check("singleCmdRejected", 1'b1, singleCmdRejected);
    tick(1);
    singleCmd = '0;
    tick(40);
    check("singleRefMv", 12'h000, singleRefMv);
    singleDisable = 1'b0;
    // ordinary cases from the table
    foreach (ROWS[r]) begin
      totalMv = 12'h000;
      imonMv = ROWS[r].current_report_indicator;
      pulsePs(ROWS[r].ps, ROWS[r].cfg);
      totalMv = ROWS[r].tot;
      tick(4);
      check("activePhaseCount", ROWS[r].expCnt, activePhaseCount);
      check("currentAtMax", ROWS[r].expMax, currentAtMax);
      check("latchState", ST_RUN, latchState);
    end
    // total over-current above the scaled level latches open
    totalMv = 12'h000;
    pulsePs(8'h01, 3'h4);
    totalMv = 12'h514;
    for (k = 0; k < 10 && latchState !== ST_HIZ; k++)
      tick(1);
    limitHit(k, 10);
    check("faultSection", SEC_MULTI, faultSection);
    tick(20);
    check("latchState", ST_HIZ, latchState);
    check("oeAll", 7'h00, oeAll);
    check("railReadyOut", 2'h2, railReadyOut);
    check("faultFlagOut", 1'b0, faultFlagOut);
    // enable cycling, like reset, is a way out of the latch
    totalMv = 12'h000;
    enableIn = 1'b0;
    tick(5);
    enableIn = 1'b1;
    tick(4);
    check("latchState", ST_RUN, latchState);
    // back to back fast commands, the newer target wins
    pulsePs(8'h00, 3'h6);
    multiCmd = '{1'b1, 1'b1, 12'h2BC};
    tick(1);
    multiCmd.targetMv = 12'h258;
    tick(1);
    multiCmd = '0;
    for (k = 0; k < 5000 && multiRefMv !== 12'h258; k++)
      tick(1);
    limitHit(k, 5000);
    check("rampCycles", 1'b1, k >= 600 * FAST_STEP_CYC - 10 &&
      k <= 600 * FAST_STEP_CYC + 40);
    tick(REARM_CYC + 50);
    check("multiRefMv", 12'h258, multiRefMv);
    // per-phase over-current holds that low side on
    phaseOcIn = 6'h01;
    tick(6);
    check("phase0", 2'b10, phasePwmOut[0]);
    phaseOcIn = 6'h00;
    tick(6);
    check("phase0", 2'b11, phasePwmOut[0]);
    // just under the over-voltage margin, then just over it
    overshootMv = 12'h0AA;
    tick(10);
    check("latchState", ST_RUN, latchState);
    overshootMv = 12'h0B4;
    for (k = 0; k < 10 && latchState !== ST_OV_RAMP; k++)
      tick(1);
    limitHit(k, 10);
    loopPwm = 7'h00;
    check("faultSection", SEC_MULTI, faultSection);
    tick(2);
    check("faultFlagOut", 1'b1, faultFlagOut);
    check("railReadyOut", 2'h2, railReadyOut);
    check("driverEnableOut", 2'h1, driverEnableOut);
    check("phase0", 2'b10, phasePwmOut[0]);
    overshootMv = 12'h000;
    for (k = 0; k < 3000 && latchState !== ST_OV_DONE; k++)
      tick(1);
    limitHit(k, 3000);
    tick(2);
    check("oeAll", 7'h00, oeAll);
    check("senseLow", 1'b1, senseMv < OV_FLOOR_MV);
    for (k = 0; k < 3000 && multiRefMv !== OV_FLOOR_MV; k++)
      tick(1);
    limitHit(k, 3000);
    tick(30);
    check("multiRefMv", OV_FLOOR_MV, multiRefMv);
    check("faultFlagOut", 1'b1, faultFlagOut);
    // change with offset: fixed level 2.4 V, margin masked
    enableIn = 1'b0;
    tick(5);
    enableIn = 1'b1;
    offsetOn = 1'b1;
    loopPwm = 7'h7F;
    tick(4);
    multiCmd = '{1'b1, 1'b1, 12'h258};
    tick(1);
    multiCmd = '0;
    overshootMv = 12'h6A4;
    tick(600 * FAST_STEP_CYC);
    overshootMv = 12'h000;
    tick(REARM_CYC / 2);
    check("latchState", ST_RUN, latchState);
    tick(REARM_CYC);
    // under-voltage once the checks are armed again
    loopPwm = 7'h00;
    for (k = 0; k < 600 && latchState !== ST_HIZ; k++)
      tick(1);
    limitHit(k, 600);
    check("faultSection", SEC_MULTI, faultSection);
    tick(2);
    check("railReadyOut", 2'h2, railReadyOut);
    check("oeAll", 7'h00, oeAll);
    conclude();
  end
endmodule // drfp_protect_tb
